// file: verilog/hpsp_cfg.svh
`ifndef HPSP_CFG_SVH
`define HPSP_CFG_SVH

// host data bus width, address width and channel count
`define HPSP_DATA_W      16
`define HPSP_ADDR_W      3
`define HPSP_CHANNELS    4

// strobe style select values
`define HPSP_MODE_SEPARATE 1'b0
`define HPSP_MODE_STROBE   1'b1

// address msb value that selects channel sample data
`define HPSP_AREA_SAMPLE   1'b0

// pin bundle reset: strobes and chip select idle high, mode low, bus zero
`define HPSP_PIN_RST     23'h700000
`define HPSP_DATA_RST    16'h0000
`define HPSP_ADDR_RST    3'h0

`endif

// file: verilog/hpsp_pkg.sv
`default_nettype none

package hpsp_pkg;

    // host pins as sampled, all levels as seen on the wires
    typedef struct packed {
        logic        ceN;
        logic        wrN;
        logic        rdN;
        logic        modeSel;
        logic [2:0]  addr;
        logic [15:0] data;
    } hpsp_pins_t;

    // write delivered to the register map, one clk cycle long
    typedef struct packed {
        logic        valid;
        logic [2:0]  addr;
        logic [15:0] data;
    } hpsp_write_t;

endpackage

`default_nettype wire

// file: verilog/hpsp_pin_sync.sv
`include "hpsp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module hpsp_pin_sync #(
    parameter int         W   = 23,
    parameter logic [W-1:0] RST = `HPSP_PIN_RST
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] pinIn,
    output var  logic [W-1:0] pinOut
);

    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;
    logic [W-1:0] stage3_q;
    logic [W-1:0] held_q;

    // three-stage chain; stage1 feeds only stage2
    always_ff @(posedge clk) begin
        if (srst) begin
            stage1_q <= RST;
            stage2_q <= RST;
            stage3_q <= RST;
        end else begin
            stage1_q <= pinIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // accept only when the last two stages agree; whole bundle moves together
    // so strobe and data stay coherent at the cost of one cycle on a skewed edge
    always_ff @(posedge clk) begin
        if (srst) begin
            held_q <= RST;
        end else if (stage2_q == stage3_q) begin
            held_q <= stage3_q;
        end
    end

    assign pinOut = held_q;

endmodule

`default_nettype wire

// file: verilog/hpsp_port.sv
// What this block does
// - separate strobes: write strobe rising edge with chip select low captures data
// - data strobe style: strobe rising edge with read_not_write low writes data
// - data strobe style: read_not_write high and strobe low drives addressed data
// - separate strobes: read strobe and chip select low drive addressed data
// - style select 0 gives separate strobes, 1 data strobe; defaults to 0
// - host data bus is bidirectional, 16 bits, bit 15 most significant
// - host can read channel output samples through the port
// - host writes reach the register map aligned to the processing clock
`include "hpsp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module hpsp_port #(
    parameter int DW    = `HPSP_DATA_W,
    parameter int AW    = `HPSP_ADDR_W,
    parameter int NCHAN = `HPSP_CHANNELS
) (
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic                      ceN,
    input  wire logic                      wrN,
    input  wire logic                      rdN,
    input  wire logic                      modeSel,
    input  wire logic [AW-1:0]             addr,
    input  wire logic [DW-1:0]             dataIn,
    output var  logic [DW-1:0]             dataOut,
    output var  logic                      dataOe,
    input  wire logic [NCHAN-1:0][DW-1:0]  chanSample,
    input  wire logic [DW-1:0]             regReadData,
    output var  logic [AW-1:0]             regReadAddr,
    output var  logic                      regRead,
    output var  logic [DW-1:0]             holdData,
    output var  logic                      wrValid,
    output var  logic [AW-1:0]             wrAddr,
    output var  logic [DW-1:0]             wrData
);

    hpsp_pkg::hpsp_pins_t  pinsRaw;
    hpsp_pkg::hpsp_pins_t  pins;
    hpsp_pkg::hpsp_write_t wr_q;
    hpsp_pkg::hpsp_write_t wr_d;

    logic          strobePrev_q;
    logic          strobeRise;
    logic          writeQual;
    logic          readActive;
    logic          styleStrobe;
    logic [DW-1:0] hold_q;
    logic [DW-1:0] dout_q;
    logic [DW-1:0] readMux;
    logic          oe_q;
    logic [AW-1:0] rdAddr_q;
    logic          rdReq_q;

    // addressed read source: low half is channel samples, high half the map
    function automatic logic [DW-1:0] pick_read(
        input logic [AW-1:0]            a,
        input logic [NCHAN-1:0][DW-1:0] samples,
        input logic [DW-1:0]            mapData
    );
        logic [DW-1:0] r;
        r = mapData;
        if (a[AW-1] == `HPSP_AREA_SAMPLE) begin
            r = samples[a[1:0]];
        end
        return r;
    endfunction

    // gather the pins so one filter treats them as a single coherent word
    always_comb begin
        pinsRaw.ceN     = ceN;
        pinsRaw.wrN     = wrN;
        pinsRaw.rdN     = rdN;
        pinsRaw.modeSel = modeSel;
        pinsRaw.addr    = addr;
        pinsRaw.data    = dataIn;
    end

    hpsp_pin_sync #(
        .W   ($bits(hpsp_pkg::hpsp_pins_t)),
        .RST (`HPSP_PIN_RST)
    ) u_sync (
        .clk    (clk),
        .srst   (srst),
        .pinIn  (pinsRaw),
        .pinOut (pins)
    );

    assign styleStrobe = (pins.modeSel == `HPSP_MODE_STROBE);

    // write pin edge tracking, shared by both styles
    always_ff @(posedge clk) begin
        if (srst) begin
            strobePrev_q <= 1'b1;
        end else begin
            strobePrev_q <= pins.wrN;
        end
    end

    assign strobeRise = pins.wrN && !strobePrev_q;

    // qualify the rising edge for the active style
    always_comb begin
        writeQual = 1'b0;
        if (!styleStrobe) begin
            writeQual = strobeRise && !pins.ceN;
        end else begin
            // data strobe, direction low means write
            writeQual = strobeRise && !pins.ceN && !pins.rdN;
        end
    end

    // read condition for the active style
    always_comb begin
        readActive = 1'b0;
        if (!styleStrobe) begin
            // read strobe and chip select both low
            readActive = !pins.rdN && !pins.ceN;
        end else begin
            // direction high while data strobe low
            readActive = pins.rdN && !pins.wrN && !pins.ceN;
        end
    end

    // holding register keeps the last captured host word
    always_ff @(posedge clk) begin
        if (srst) begin
            hold_q <= `HPSP_DATA_RST;
        end else if (writeQual) begin
            hold_q <= pins.data;
        end
    end

    // write issued as a single clk pulse so all channels update together
    always_comb begin
        wr_d.valid = writeQual;
        wr_d.addr  = pins.addr;
        wr_d.data  = pins.data;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q.valid <= 1'b0;
            wr_q.addr  <= `HPSP_ADDR_RST;
            wr_q.data  <= `HPSP_DATA_RST;
        end else begin
            wr_q.valid <= wr_d.valid;
            if (wr_d.valid) begin
                wr_q.addr <= wr_d.addr;
                wr_q.data <= wr_d.data;
            end
        end
    end

    // address handed to the register map every cycle, read open or not
    always_ff @(posedge clk) begin
        if (srst) begin
            rdAddr_q <= `HPSP_ADDR_RST;
            rdReq_q  <= 1'b0;
        end else begin
            rdAddr_q <= pins.addr;
            rdReq_q  <= readActive;
        end
    end

    // channel samples share the read path with map data
    assign readMux = pick_read(pins.addr, chanSample, regReadData);

    // read data refreshes every cycle the read condition holds so a long strobe sees live samples
    always_ff @(posedge clk) begin
        if (srst) begin
            dout_q <= `HPSP_DATA_RST;
        end else if (readActive) begin
            dout_q <= readMux;
        end
    end

    // enable only while the read condition holds
    always_ff @(posedge clk) begin
        if (srst) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= readActive;
        end
    end

    assign dataOut     = dout_q;
    assign dataOe      = oe_q;
    assign regReadAddr = rdAddr_q;
    assign regRead     = rdReq_q;
    assign holdData    = hold_q;
    assign wrValid     = wr_q.valid;
    assign wrAddr      = wr_q.addr;
    assign wrData      = wr_q.data;

endmodule

`default_nettype wire

// file: verif/hpsp_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
module hpsp_port_properties #(
    parameter int DW    = 16,
    parameter int AW    = 3,
    parameter int NCHAN = 4
) (
    input wire logic                    clk,
    input wire logic                    srst,
    input wire logic                    ceN,
    input wire logic                    wrN,
    input wire logic                    rdN,
    input wire logic                    modeSel,
    input wire logic [AW-1:0]           addr,
    input wire logic [DW-1:0]           dataIn,
    input wire logic [DW-1:0]           dataOut,
    input wire logic                    dataOe,
    input wire logic [NCHAN-1:0][DW-1:0] chanSample,
    input wire logic [DW-1:0]           regReadData,
    input wire logic [AW-1:0]           regReadAddr,
    input wire logic                    regRead,
    input wire logic                    wrValid,
    input wire logic [AW-1:0]           wrAddr,
    input wire logic [DW-1:0]           wrData,
    input wire logic [DW-1:0]           holdData
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // read and idle conditions held long enough to clear the pin filter
    sequence rd0_s; (!ceN && !rdN && !modeSel)[*8]; endsequence
    sequence rd1_s; (!ceN && rdN && !wrN && modeSel)[*8]; endsequence
    sequence idle_s; (ceN || (modeSel ? (!rdN || wrN) : rdN))[*8]; endsequence
    wr_select_a: assert property (wrValid |-> !$past(ceN, 3))
        else $error("write taken without select");
    wr_dir_a: assert property (wrValid && modeSel |-> !$past(rdN, 3))
        else $error("strobe write taken while reading");
    wr_data_a: assert property (wrValid |-> wrData == $past(dataIn, 3))
        else $error("write data differs from bus");
    wr_addr_a: assert property (wrValid |-> wrAddr == $past(addr, 3))
        else $error("write address differs");
    hold_match_a: assert property (wrValid |-> holdData == wrData)
        else $error("holding register differs");
    wr_pulse_a: assert property (wrValid |=> !wrValid)
        else $error("write pulse too long");
    wr_keep_a: assert property (!wrValid |-> $stable(wrData) && $stable(holdData))
        else $error("write data moved without write");
    read_drive_a: assert property (rd0_s |-> dataOe)
        else $error("no drive on strobe read");
    strobe_drive_a: assert property (rd1_s |-> dataOe)
        else $error("no drive on data strobe read");
    read_data_a: assert property (rd0_s or rd1_s |->
        dataOut == (addr[2] ? regReadData : chanSample[addr[1:0]]))
        else $error("read data wrong");
    rd_request_a: assert property (rd0_s or rd1_s |-> regRead && regReadAddr == addr)
        else $error("map read request wrong");
    bus_idle_a: assert property (idle_s |-> !dataOe)
        else $error("bus driven while idle");
endmodule
bind hpsp_port hpsp_port_properties #(.DW(DW), .AW(AW), .NCHAN(NCHAN)) i_hpsp_port_properties (.*);
`default_nettype wire

// file: verif/hpsp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hpsp_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] busIn,
    output var  logic        ceN,
    output var  logic        wrN,
    output var  logic        rdN,
    output var  logic        modeSel,
    output var  logic [2:0]  addr,
    output var  logic [15:0] busDrv
);
    // idle pins; style strap left at its pulled-down level
    initial begin
        ceN = 1;
        wrN = 1;
        rdN = 1;
        modeSel = 0;
        addr = 0;
        busDrv = 16'h5a5a;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one transfer; phases kept at least three clocks so the filter sees them
    task automatic xfer(input logic m, input logic rd, input logic en,
                        input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
        modeSel = m;
        ceN = !en;
        addr = a;
        busDrv = rd ? ~busDrv : d;
        rdN = m ? rd : 1'b1;
        tick(3);
        if (!m && rd) rdN = 0;
        else wrN = 0;
        tick(10);
        q = busIn;
        rdN = m ? rd : 1'b1;
        wrN = 1;
        tick(6);
        ceN = 1;
        busDrv = ~busDrv; // released bus shows no stale value
        tick(6);
    endtask
endmodule
`default_nettype wire

// file: verif/tb_hpsp_port.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_hpsp_port;
    logic             clk = 0;
    logic             srst = 1;
    logic             ceN, wrN, rdN, modeSel, dataOe, regRead, wrValid;
    logic [2:0]       addr, wrAddr, regReadAddr;
    logic [15:0]      busDrv, dataIn, dataOut, holdData, wrData, q;
    logic [3:0][15:0] chanSample = {16'h4004, 16'h3003, 16'h2002, 16'h1001};
    logic [15:0]      regReadData = 16'hc0de;
    int               errors = 0, total_checks = 0, wrCount = 0;
    always #20 clk = ~clk;
    // wire level: device while enabled, host otherwise
    assign dataIn = dataOe ? dataOut : busDrv;
    // count delivered writes
    always @(posedge clk) if (wrValid) wrCount++;
    hpsp_port i_hpsp_port (.*);
    hpsp_host_model i_hpsp_host_model (.busIn(dataIn), .*);
    task automatic wr_case(input logic m, input logic [2:0] a, input logic [15:0] d);
        int n;
        n = wrCount;
        i_hpsp_host_model.xfer(m, 1'b0, 1'b1, a, d, q);
        `CHK("wrCount", n + 1, wrCount)
        `CHK("wrData", d, wrData)
        `CHK("wrAddr", a, wrAddr)
        `CHK("holdData", d, holdData)
    endtask
    task automatic wr_refused();
        int n;
        n = wrCount;
        i_hpsp_host_model.xfer(1'b0, 1'b0, 1'b0, 3'h5, 16'hbad0, q);
        `CHK("wrCount", n, wrCount)
        `CHK("holdData", 16'h8001, holdData)
    endtask
    task automatic rd_case(input logic m, input logic [2:0] a);
        i_hpsp_host_model.xfer(m, 1'b1, 1'b1, a, 16'h0000, q);
        `CHK("rdData", a[2] ? regReadData : chanSample[a[1:0]], q)
        `CHK("dataOe", 1'b0, dataOe)
        `CHK("regRead", 1'b0, regRead)
        `CHK("regReadAddr", a, regReadAddr)
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // reset, then writes in both styles, a refused write and reads of every place
    initial begin
        repeat (20) @(posedge clk);
        #1;
        srst = 0;
        wr_case(1'b0, 3'h6, 16'h7ffe);
        wr_case(1'b1, 3'h1, 16'h8001);
        wr_refused();
        for (int a = 0; a < 8; a++) rd_case(1'b0, 3'(a));
        rd_case(1'b1, 3'h2);
        rd_case(1'b1, 3'h7);
        `CHK("holdData", 16'h8001, holdData)
        complete_run();
    end
endmodule
`default_nettype wire
